// ==== tb/mts_dsp_model.sv ====
// signal processor model taking packed words
`timescale 1ns/1ps
module mts_dsp_model (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        stall,
    input wire logic        slow,
    input wire logic [31:0] dsp_data,
    input wire logic        dsp_valid,
    output logic            dsp_ready
);
    logic [31:0] words[$];
    // takes words at full or half rate, holds off on stall
    // sine dac reference comes from the processor's own 10-bit dac, off this link
    always @(posedge clk)
    begin
        if (!reset_n)
            words.delete();
        else if (dsp_valid && dsp_ready)
            words.push_back(dsp_data);
        dsp_ready <= reset_n && !stall && !(slow && dsp_ready);
    end
endmodule

// ==== tb/mts_seq_monitor.sv ====
// assertion checker on the sequencer ports
`timescale 1ns/1ps
module mts_seq_monitor (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        run,
    input wire logic        raw_mode,
    input wire logic [11:0] mod_dac,
    input wire logic [9:0]  gain_dac,
    input wire logic        pulse_out,
    input wire logic        sample_latch,
    input wire logic [15:0] servo_mult,
    input wire logic [31:0] dsp_data,
    input wire logic        dsp_valid,
    input wire logic        dsp_ready,
    input wire logic        overflow
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ****
    // cycles since run low, latches since reset
    // ****
    logic [3:0] idle_q, idle_d;
    logic [2:0] lat_q, lat_d;
    logic       raw_q, raw_d;
    always_comb
    begin
        idle_d = run ? 4'h0 : idle_q + 4'(idle_q != 4'hf);
        lat_d  = lat_q + 3'(sample_latch && lat_q != 3'h5);
        raw_d  = raw_q | raw_mode;
    end
    always_ff @(posedge clk)
    begin
        idle_q <= reset_n ? idle_d : 4'hf;
        lat_q  <= reset_n ? lat_d : 3'h0;
        raw_q  <= reset_n & raw_d;
    end
    // ****
    // assertions
    // ****
    a_fields_stand: assert property (@(posedge clk) disable iff (!reset_n || !run)
        $changed(mod_dac) |=> ($stable(mod_dac) && $stable(gain_dac))[*3])
        else $error("table fields changed inside one step");
    a_pulse_single: assert property (pulse_out |=> !pulse_out)
        else $error("pulse longer than one cycle");
    a_latch_single: assert property (sample_latch |=> !sample_latch)
        else $error("latch longer than one cycle");
    a_idle_quiet: assert property ((pulse_out || sample_latch) |-> idle_q < 4'hc)
        else $error("pulse while stopped");
    a_five_latches: assert property (dsp_valid |-> lat_q == 3'h5 || raw_q)
        else $error("word before five latches");
    a_fifo_hold: assert property (dsp_valid && !dsp_ready |=> dsp_valid && $stable(dsp_data))
        else $error("word dropped while stalled");
    a_mult_reset: assert property ($rose(reset_n) |-> servo_mult == mts_pkg::MULT_RESET)
        else $error("multiplier reset value wrong");
    a_mult_needs_data: assert property (servo_mult != mts_pkg::MULT_RESET |-> lat_q == 3'h5)
        else $error("multiplier moved without samples");
    a_overflow_sticky: assert property (overflow |=> overflow)
        else $error("overflow flag cleared");
    c_pulse: cover property (pulse_out);
    c_take: cover property (dsp_valid && dsp_ready);
    c_stall: cover property (dsp_valid && !dsp_ready);
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the modulation timing sequencer
`timescale 1ns/1ps
module tb;
    typedef struct {
        logic [11:0] s;
        logic [9:0]  g;
        logic [2:0]  f;
        logic        pe;
        logic [1:0]  pp;
        logic        se;
        logic [1:0]  sp;
    } mts_row_s;
    logic        clk, reset_n, run, table_wr, raw_mode, servo_enable, stall, slow;
    logic        pulse_out, sample_latch, first_pos_slope, odd_pulse, sync_switch, dsp_valid, dsp_ready, overflow;
    logic [7:0]  table_last, table_wr_addr;
    logic [31:0] table_wr_data, dsp_data;
    logic [13:0] adc_rx0, adc_rx1, adc_rx2;
    logic [1:0]  raw_select, servo_rx;
    logic [4:0]  servo_shift;
    logic [11:0] mod_dac;
    logic [9:0]  gain_dac;
    logic [15:0] servo_mult, m1;
    logic [13:0] seq[5] = '{14'h400, 14'h800, 14'h100, 14'h200, 14'h600};
    int          mismatches, num_checks, cyc, tp, ts, n0;
    mts_row_s    rows[5] = '{
        '{12'h111, 10'h3ff, 3'h1, 1'b1, 2'h0, 1'b1, 2'h0},
        '{12'h222, 10'h155, 3'h2, 1'b1, 2'h1, 1'b1, 2'h3},
        '{12'h333, 10'h2aa, 3'h4, 1'b1, 2'h2, 1'b0, 2'h2},
        '{12'h444, 10'h001, 3'h7, 1'b1, 2'h3, 1'b1, 2'h1},
        '{12'h555, 10'h200, 3'h0, 1'b0, 2'h3, 1'b1, 2'h2}};
    mts_sequencer dut (
        .clk, .reset_n, .run, .table_last, .table_wr, .table_wr_addr, .table_wr_data,
        .adc_rx0, .adc_rx1, .adc_rx2, .raw_mode, .raw_select, .servo_enable, .servo_shift,
        .servo_rx, .mod_dac, .gain_dac, .pulse_out, .sample_latch, .first_pos_slope,
        .odd_pulse, .sync_switch, .servo_mult, .dsp_data, .dsp_valid, .dsp_ready, .overflow);
    mts_dsp_model dsp (.clk, .reset_n, .stall, .slow, .dsp_data, .dsp_valid, .dsp_ready);
    // ****
    // tasks
    // ****
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(negedge clk);
        table_wr = 1'b1;
        table_wr_addr = a;
        table_wr_data = d;
        @(negedge clk);
        table_wr = 1'b0;
    endtask
    task automatic set_adc(int n);
        logic [13:0] v;
        v = (n < 5) ? seq[n] : 14'h100;
        adc_rx0 = v;
        adc_rx1 = 14'(v * 2);
        adc_rx2 = 14'(v * 3);
    endtask
    task automatic wait_dac(logic [11:0] v);
        int n;
        n = 0;
        while (mod_dac !== v && n < 64)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic wait_latch();
        int n;
        n = 0;
        while (sample_latch !== 1'b1 && n < 64)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    // packed pair of receiver r for the first sample set
    function automatic logic [31:0] pk(int r);
        int cs, sn;
        cs = (r + 1) * (seq[0] - 2 * seq[2] + seq[4]);
        sn = (r + 1) * 2 * (seq[1] - seq[3]);
        return {sn[16:1], cs[16:1]};
    endfunction
    // ****
    // clock, timeout and sequence
    // ****
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            finish_test();
        end
    end
    initial
    begin
        {run, table_wr, raw_mode, servo_enable, stall, slow, reset_n} = 7'h0;
        {raw_select, servo_rx, servo_shift, table_wr_addr, table_wr_data} = '0;
        table_last = 8'h1;
        set_adc(0);
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        foreach (rows[i])
        begin
            run = 1'b0;
            repeat (6) @(negedge clk);
            wr(8'h0, 32'h0);
            wr(8'h1, {1'b0, rows[i].f, rows[i].sp, rows[i].se, rows[i].pp, rows[i].pe, rows[i].g, rows[i].s});
            run = 1'b1;
            wait_dac(rows[i].s);
            check("sine", mod_dac, rows[i].s);
            check("gain", gain_dac, rows[i].g);
            check("flags", {sync_switch, odd_pulse, first_pos_slope}, rows[i].f);
            tp = -1;
            ts = -1;
            for (int k = 0; k < 8; k++)
            begin
                if (k == 4)
                    check("wrap", mod_dac, 12'h0);
                if (pulse_out === 1'b1 && tp < 0)
                    tp = k;
                if (sample_latch === 1'b1 && ts < 0)
                    ts = k;
                @(negedge clk);
            end
            check("period", mod_dac, rows[i].s);
            check("pulse", tp, rows[i].pe ? rows[i].pp : -1);
            check("latch", ts, rows[i].se ? rows[i].sp : -1);
        end
        // ****
        // ten latches, slow processor
        // ****
        run = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        wr(8'h0, 32'h0ac0_07ff);
        wr(8'h1, 32'h0);
        servo_enable = 1'b1;
        servo_shift = 5'h2;
        servo_rx = 2'h1;
        slow = 1'b1;
        run = 1'b1;
        for (int n = 1; n <= 10; n++)
        begin
            wait_latch();
            repeat (4) @(negedge clk);
            set_adc(n);
            if (n == 9)
                m1 = servo_mult;
        end
        n0 = 0;
        while (dsp.words.size() < 6 && n0 < 200)
        begin
            @(negedge clk);
            n0++;
        end
        run = 1'b0;
        slow = 1'b0;
        check("words", dsp.words.size(), 6);
        for (int r = 0; r < 6; r++)
            check("packed", dsp.words[r], r < 3 ? pk(r) : 32'h0);
        check("servo step", m1, 16'h4100);
        check("servo held", servo_mult, m1);
        // ****
        // raw stream, then buffer fill and drain
        // ****
        for (int r = 0; r < 4; r++)
        begin
            raw_select = 2'(r);
            raw_mode = 1'b1;
            repeat (10) @(negedge clk);
            n0 = dsp.words.size();
            repeat (40) @(negedge clk);
            check("raw rate", dsp.words.size() - n0 inside {[19:21]}, 1'b1);
            check("raw word", dsp.words[$], {18'h0, r == 0 ? adc_rx0 : r == 1 ? adc_rx1 : adc_rx2});
            raw_mode = 1'b0;
            repeat (10) @(negedge clk);
        end
        stall = 1'b1;
        raw_mode = 1'b1;
        repeat (120) @(negedge clk);
        check("full valid", dsp_valid, 1'b1);
        check("overflow", overflow, 1'b1);
        raw_mode = 1'b0;
        n0 = dsp.words.size();
        repeat (10) @(negedge clk);
        stall = 1'b0;
        repeat (100) @(negedge clk);
        check("drained", dsp.words.size() - n0 inside {[32:33]}, 1'b1);
        check("empty", dsp_valid, 1'b0);
        run = 1'b1;
        repeat (30) @(negedge clk);
        reset_n = 1'b0;
        @(negedge clk);
        check("reset out", {mod_dac, gain_dac, pulse_out, sample_latch, dsp_valid, overflow}, 0);
        check("reset mult", servo_mult, 16'h4000);
        reset_n = 1'b1;
        finish_test();
    end
endmodule
bind mts_sequencer mts_seq_monitor u_mon (.clk, .reset_n, .run, .raw_mode, .mod_dac, .gain_dac, .pulse_out,
    .sample_latch, .servo_mult, .dsp_data, .dsp_valid, .dsp_ready, .overflow);

// ==== verilog/mts_fifo.sv ====
// parameterised valid/ready fifo for packed sample words
`timescale 1ns/1ps
module mts_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      wr_d;
    logic [AW:0]      rd_q;
    logic [AW:0]      rd_d;
    logic             push;
    logic             pop;

    always_comb
    begin
        in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
        out_valid = wr_q != rd_q;
        out_data  = mem[rd_q[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_d      = push ? wr_q + 1'b1 : wr_q;
        rd_d      = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
        if (push)
            mem[wr_q[AW-1:0]] <= in_data;
    end
endmodule

// ==== verilog/mts_pkg.sv ====
// shared constants for the modulation timing sequencer
package mts_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ        = 100;
    localparam int TABLE_MHZ      = 25;
    localparam int TICKS_PER_STEP = CLK_MHZ / TABLE_MHZ;
    localparam int DAC_STEP_NS    = 40;
    localparam int CLK_NS         = 10;
    localparam int DAC_STEP_TICKS = DAC_STEP_NS / CLK_NS;
    localparam int RAW_DIV        = CLK_MHZ / 50;
    // ****************************************
    // sampling
    // ****************************************
    localparam int NUM_RX         = 3;
    localparam int SAMPLES_PER_RX = 5;
    localparam int ADC_W          = 14;
    localparam int WORD_W         = 32;
    localparam int HALF_W         = 16;
    // ****************************************
    // timing table entry layout
    // ****************************************
    localparam int ENTRY_W        = 32;
    localparam int SINE_LSB       = 0;
    localparam int SINE_W         = 12;
    localparam int GAIN_LSB       = 12;
    localparam int GAIN_W         = 10;
    localparam int PEN_BIT        = 22;
    localparam int PPH_LSB        = 23;
    localparam int SEN_BIT        = 25;
    localparam int SPH_LSB        = 26;
    localparam int PH_W           = 2;
    localparam int FIRST_POS_BIT  = 28;
    localparam int ODD_BIT        = 29;
    localparam int SWITCH_BIT     = 30;
    // ****************************************
    // servo
    // ****************************************
    localparam int MULT_W         = 16;
    localparam logic [15:0] MULT_RESET = 16'h4000;
    localparam int ACC_W          = 32;
endpackage

// ==== verilog/mts_sequencer.sv ====
// timing table sequencer, sample reduction, packing and modulation servo
//
// Behaviour
// R1: capture five samples per receiver for each return, fifteen in all.
// R2: adc samples arrive at 100 MHz on every receiver channel.
// R3: reduce each receiver's five samples to one sine/cosine pair.
// R4: pack three pairs into three 32-bit words for the processor.
// R5: step the sine table to the dac every 40 ns and wrap.
// R6: measure amplitude from quarter-phase samples and form multiplier error.
// R7: sine sits inside a wider timing table stepped at 25 MHz.
// R8: pulse enable starts optical pulse after phase-field 10 ns clocks.
// R9: sample enable and phase delay adc latching the same way.
// R10: table gain field drives the 10-bit receiver gain dac.
// R11: output first positive-slope sample marker and even/odd pulse flag.
// R12: drive a switch output from a table bit for external sync.
// R13: raw mode passes one receiver's samples at 50 MHz.
// R14: processor sets modulation dac reference through its own dac.
// R15: positive-slope pulse is even, negative-slope pulse is odd.
// R16: error accumulates into an integral servo with adjustable time constant.
// R17: samples spaced by a quarter-wave modulation phase shift.
// R18: phase delays counted on the 100 MHz clock, four per step.
// R19: phase fields two bits, effective only when their enable is set.
`timescale 1ns/1ps
module mts_sequencer #(
    parameter int TABLE_DEPTH = 256,
    parameter int FIFO_DEPTH  = 32,
    parameter int ADC_W       = mts_pkg::ADC_W
) (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      run,
    input  wire logic [$clog2(TABLE_DEPTH)-1:0] table_last,
    input  wire logic                      table_wr,
    input  wire logic [$clog2(TABLE_DEPTH)-1:0] table_wr_addr,
    input  wire logic [31:0]               table_wr_data,
    input  wire logic [ADC_W-1:0]          adc_rx0,
    input  wire logic [ADC_W-1:0]          adc_rx1,
    input  wire logic [ADC_W-1:0]          adc_rx2,
    input  wire logic                      raw_mode,
    input  wire logic [1:0]                raw_select,
    input  wire logic                      servo_enable,
    input  wire logic [4:0]                servo_shift,
    input  wire logic [1:0]                servo_rx,
    output logic [mts_pkg::SINE_W-1:0]     mod_dac,
    output logic [mts_pkg::GAIN_W-1:0]     gain_dac,
    output logic                           pulse_out,
    output logic                           sample_latch,
    output logic                           first_pos_slope,
    output logic                           odd_pulse,
    output logic                           sync_switch,
    output logic [mts_pkg::MULT_W-1:0]     servo_mult,
    output logic [31:0]                    dsp_data,
    output logic                           dsp_valid,
    input  wire logic                      dsp_ready,
    output logic                           overflow
);
    localparam int TAW = $clog2(TABLE_DEPTH);
    localparam int SW  = ADC_W + 3;

    initial
    begin
        if (TABLE_DEPTH < 4 || ADC_W > mts_pkg::HALF_W || ADC_W < 4)
            $error("unsupported table depth or adc width");
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [ADC_W-1:0] adc_m_q [mts_pkg::NUM_RX];
    logic [ADC_W-1:0] adc_q   [mts_pkg::NUM_RX];
    logic [ADC_W-1:0] adc_raw [mts_pkg::NUM_RX];
    logic             run_m_q;
    logic             run_q;
    logic             raw_m_q;
    logic             raw_q;

    assign adc_raw[0] = adc_rx0;
    assign adc_raw[1] = adc_rx1;
    assign adc_raw[2] = adc_rx2;

    always_ff @(posedge clk)
    begin
        // every receiver sampled on each 100 MHz edge [R2]
        for (int i = 0; i < mts_pkg::NUM_RX; i++)
        begin
            adc_m_q[i] <= adc_raw[i];
            adc_q[i]   <= adc_m_q[i];
        end
        if (!reset_n)
        begin
            run_m_q <= 1'b0;
            run_q   <= 1'b0;
            raw_m_q <= 1'b0;
            raw_q   <= 1'b0;
        end
        else
        begin
            run_m_q <= run;
            run_q   <= run_m_q;
            raw_m_q <= raw_mode;
            raw_q   <= raw_m_q;
        end
    end

    // ****************************************
    // timing table and stepping
    // ****************************************
    logic [31:0]    tbl [TABLE_DEPTH];
    logic [TAW-1:0] addr_q;
    logic [TAW-1:0] addr_d;
    logic [1:0]     tick_q;
    logic [1:0]     tick_d;
    logic [31:0]    entry_q;
    logic [31:0]    entry_d;
    logic           step;

    always_ff @(posedge clk)
    begin
        if (table_wr)
            tbl[table_wr_addr] <= table_wr_data;
    end

    always_comb
    begin
        // four 100 MHz clocks per 25 MHz table step [R18]
        step   = run_q && tick_q == 2'(mts_pkg::TICKS_PER_STEP - 1);
        tick_d = run_q ? tick_q + 2'h1 : 2'h0;
        addr_d = addr_q;
        entry_d = entry_q;
        if (step)
        begin
            // wrap to first entry after full modulation cycle [R5] [R7]
            addr_d  = (addr_q == table_last) ? '0 : addr_q + 1'b1;
            entry_d = tbl[addr_q];
        end
        else if (!run_q)
        begin
            addr_d  = '0;
            entry_d = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            addr_q  <= '0;
            tick_q  <= '0;
            entry_q <= '0;
        end
        else
        begin
            addr_q  <= addr_d;
            tick_q  <= tick_d;
            entry_q <= entry_d;
        end
    end

    // ****************************************
    // table field outputs
    // ****************************************
    logic       new_entry_q;
    logic [1:0] pdly_q;
    logic [1:0] pdly_d;
    logic [1:0] sdly_q;
    logic [1:0] sdly_d;
    logic       parm_q;
    logic       parm_d;
    logic       sarm_q;
    logic       sarm_d;
    logic       pulse_d;
    logic       latch_d;

    always_comb
    begin
        parm_d  = parm_q;
        sarm_d  = sarm_q;
        pdly_d  = pdly_q;
        sdly_d  = sdly_q;
        pulse_d = 1'b0;
        latch_d = 1'b0;
        if (new_entry_q)
        begin
            // phase only meaningful with its enable set [R19]
            parm_d = entry_q[mts_pkg::PEN_BIT];
            pdly_d = entry_q[mts_pkg::PPH_LSB +: mts_pkg::PH_W];
            sarm_d = entry_q[mts_pkg::SEN_BIT];
            sdly_d = entry_q[mts_pkg::SPH_LSB +: mts_pkg::PH_W];
        end
        // fire after phase-value 10 ns clocks [R8]
        if (parm_d)
        begin
            if (pdly_d == 2'h0)
            begin
                pulse_d = 1'b1;
                parm_d  = 1'b0;
            end
            else
                pdly_d = pdly_d - 2'h1;
        end
        // latch delayed the same way [R9]
        if (sarm_d)
        begin
            if (sdly_d == 2'h0)
            begin
                latch_d = 1'b1;
                sarm_d  = 1'b0;
            end
            else
                sdly_d = sdly_d - 2'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            new_entry_q     <= 1'b0;
            parm_q          <= 1'b0;
            sarm_q          <= 1'b0;
            pdly_q          <= '0;
            sdly_q          <= '0;
            pulse_out       <= 1'b0;
            sample_latch    <= 1'b0;
            mod_dac         <= '0;
            gain_dac        <= '0;
            first_pos_slope <= 1'b0;
            odd_pulse       <= 1'b0;
            sync_switch     <= 1'b0;
        end
        else
        begin
            new_entry_q     <= step;
            parm_q          <= parm_d;
            sarm_q          <= sarm_d;
            pdly_q          <= pdly_d;
            sdly_q          <= sdly_d;
            pulse_out       <= pulse_d;
            sample_latch    <= latch_d;
            mod_dac         <= entry_q[mts_pkg::SINE_LSB +: mts_pkg::SINE_W];   // [R5]
            gain_dac        <= entry_q[mts_pkg::GAIN_LSB +: mts_pkg::GAIN_W];   // [R10]
            first_pos_slope <= entry_q[mts_pkg::FIRST_POS_BIT];                 // [R11]
            odd_pulse       <= entry_q[mts_pkg::ODD_BIT];                       // [R11] [R15]
            sync_switch     <= entry_q[mts_pkg::SWITCH_BIT];                    // [R12]
        end
    end

    // ****************************************
    // sample capture and reduction
    // ****************************************
    // samples quarter-wave apart: s0..s4 at 0,90,180,270,360 deg [R17]
    logic [2:0]           cnt_q;
    logic [2:0]           cnt_d;
    logic signed [SW-1:0] sin_q [mts_pkg::NUM_RX];
    logic signed [SW-1:0] sin_d [mts_pkg::NUM_RX];
    logic signed [SW-1:0] cos_q [mts_pkg::NUM_RX];
    logic signed [SW-1:0] cos_d [mts_pkg::NUM_RX];
    logic                 done_d;
    logic                 done_q;

    always_comb
    begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        for (int i = 0; i < mts_pkg::NUM_RX; i++)
        begin
            sin_d[i] = sin_q[i];
            cos_d[i] = cos_q[i];
        end
        if (sample_latch && !raw_q)
        begin
            // five samples on each of three receivers [R1]
            for (int i = 0; i < mts_pkg::NUM_RX; i++)
            begin
                // cos = s0 - 2 s2 + s4, sin = 2 (s1 - s3) [R3]
                unique case (cnt_q)
                    3'h0: cos_d[i] = SW'(signed'({1'b0, adc_q[i]}));
                    3'h1: sin_d[i] = SW'(signed'({1'b0, adc_q[i]})) <<< 1;
                    3'h2: cos_d[i] = cos_q[i] - (SW'(signed'({1'b0, adc_q[i]})) <<< 1);
                    3'h3: sin_d[i] = sin_q[i] - (SW'(signed'({1'b0, adc_q[i]})) <<< 1);
                    default: cos_d[i] = cos_q[i] + SW'(signed'({1'b0, adc_q[i]}));
                endcase
            end
            if (cnt_q == 3'(mts_pkg::SAMPLES_PER_RX - 1))
            begin
                cnt_d  = '0;
                done_d = 1'b1;
            end
            else
                cnt_d = cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            cnt_q  <= '0;
            done_q <= 1'b0;
            for (int i = 0; i < mts_pkg::NUM_RX; i++)
            begin
                sin_q[i] <= '0;
                cos_q[i] <= '0;
            end
        end
        else
        begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
            for (int i = 0; i < mts_pkg::NUM_RX; i++)
            begin
                sin_q[i] <= sin_d[i];
                cos_q[i] <= cos_d[i];
            end
        end
    end

    // ****************************************
    // packing into fifo words and raw mode
    // ****************************************
    logic [1:0]  pk_q;
    logic [1:0]  pk_d;
    logic        pk_busy_q;
    logic        pk_busy_d;
    logic        rdiv_q;
    logic        rdiv_d;
    logic [31:0] f_data;
    logic        f_valid;
    logic        f_ready;
    logic        ovf_d;

    always_comb
    begin
        pk_d      = pk_q;
        pk_busy_d = pk_busy_q;
        rdiv_d    = raw_q ? ~rdiv_q : 1'b0;
        f_valid   = 1'b0;
        f_data    = '0;
        if (raw_q)
        begin
            // every second clock gives the 50 MHz raw stream [R13]
            f_valid = rdiv_q;
            f_data  = 32'(adc_q[raw_select == 2'h0 ? 0 : raw_select == 2'h1 ? 1 : 2]);
        end
        else if (pk_busy_q)
        begin
            // one word per receiver: sine high half, cosine low half [R4]
            f_valid = 1'b1;
            f_data  = {sin_q[pk_q][SW-1 -: mts_pkg::HALF_W], cos_q[pk_q][SW-1 -: mts_pkg::HALF_W]};
            if (f_ready)
            begin
                if (pk_q == 2'(mts_pkg::NUM_RX - 1))
                begin
                    pk_d      = '0;
                    pk_busy_d = 1'b0;
                end
                else
                    pk_d = pk_q + 2'h1;
            end
        end
        if (done_q)
            pk_busy_d = 1'b1;
        ovf_d = overflow || (f_valid && !f_ready) && raw_q || (done_q && pk_busy_q);
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pk_q      <= '0;
            pk_busy_q <= 1'b0;
            rdiv_q    <= 1'b0;
            overflow  <= 1'b0;
        end
        else
        begin
            pk_q      <= pk_d;
            pk_busy_q <= pk_busy_d;
            rdiv_q    <= rdiv_d;
            overflow  <= ovf_d;
        end
    end

    mts_fifo #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_data   (f_data),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .out_data  (dsp_data),
        .out_valid (dsp_valid),
        .out_ready (dsp_ready)
    );

    // ****************************************
    // modulation amplitude servo
    // ****************************************
    logic signed [mts_pkg::ACC_W-1:0] acc_q;
    logic signed [mts_pkg::ACC_W-1:0] acc_d;
    logic signed [mts_pkg::ACC_W-1:0] err;
    logic [1:0]                       srx;
    logic [mts_pkg::MULT_W-1:0]       mult_d;

    always_comb
    begin
        srx = servo_rx > 2'h2 ? 2'h2 : servo_rx;
        // equal quarter steps give s0+s4 = s2-ish: amplitude error is cos term minus half sin term [R6]
        err   = mts_pkg::ACC_W'(cos_q[srx]) - mts_pkg::ACC_W'(sin_q[srx] >>> 1);
        acc_d = acc_q;
        if (servo_enable && done_q)
            acc_d = acc_q + (err >>> servo_shift);                     // [R16]
        mult_d = mts_pkg::MULT_RESET + acc_d[mts_pkg::MULT_W-1:0];     // [R6]
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            acc_q      <= '0;
            servo_mult <= mts_pkg::MULT_RESET;
        end
        else
        begin
            acc_q      <= acc_d;
            servo_mult <= mult_d;
        end
    end
endmodule
